// >>> verilog/dcfg_pkg.sv
// Package: offsets, field positions, reset values and encodings of the data configuration block
package dcfg_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] DATA_CONFIG_OFS = 4'hE;
  localparam logic [ADDR_W-1:0] TX_CONFIG_OFS = 4'hD;
  localparam int WORD_SEL_BIT = 0;
  localparam int ORDER_SEL_BIT = 1;
  localparam int LONG_SEL_BIT = 2;
  localparam int LSEL_BIT = 3;
  localparam int ARM_BIT = 4;
  localparam int FT_LSB = 5;
  localparam int LBC_LSB = 1;
  localparam logic [7:0] DATA_CONFIG_RST = 8'h04;
  localparam logic [1:0] LOOP_CODE_RST = 2'h0;
  localparam logic [4:0] FIFO_BYTES = 5'h10;
  localparam logic [4:0] RX_THRESH_RST = 5'h02;
  localparam logic [4:0] TX_THRESH_RST = 5'h0E;
  localparam logic [3:0] BURST_LEN_RST = 4'h2;
  localparam logic [3:0] THRESH_UNITS_0 = 4'h1;
  localparam logic [3:0] THRESH_UNITS_1 = 4'h2;
  localparam logic [3:0] THRESH_UNITS_2 = 4'h4;
  localparam logic [3:0] THRESH_UNITS_3 = 4'h6;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  typedef enum logic [1:0] {
    LB_NORMAL = 2'b00,
    LB_CONTROLLER = 2'b01,
    LB_ENCODER = 2'b10,
    LB_EXTERNAL = 2'b11
  } loop_mode_t;
endpackage : dcfg_pkg

// >>> verilog/dcfg_thresh.sv
// Threshold decoder: FIFO code to receive and transmit byte counts and a burst count in bytes or words
`timescale 1ns/100ps
`default_nettype none
module dcfg_thresh (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] code,
  input wire logic word_mode,
  output logic [4:0] rx_bytes_q,
  output logic [4:0] tx_bytes_q,
  output logic [3:0] burst_units_q
);
  import dcfg_pkg::*;
  logic [3:0] units_d;
  always_comb begin
    case (code)
      2'b00: units_d = THRESH_UNITS_0;
      2'b01: units_d = THRESH_UNITS_1;
      2'b10: units_d = THRESH_UNITS_2;
      default: units_d = THRESH_UNITS_3;
    endcase
  end
  // Word or byte thresholds are the same byte count
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_bytes_q <= RX_THRESH_RST;
      tx_bytes_q <= TX_THRESH_RST;
      burst_units_q <= BURST_LEN_RST;
    end else begin
      rx_bytes_q <= {units_d, 1'b0};
      tx_bytes_q <= FIFO_BYTES - {units_d, 1'b0};
      burst_units_q <= word_mode ? units_d : {units_d[2:0], 1'b0};
    end
  end
endmodule : dcfg_thresh
`default_nettype wire

// >>> verilog/dcfg_top.sv
// Data configuration register bank steering DMA width, order, addressing, loopback and FIFO threshold
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dcfg_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [dcfg_pkg::ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [15:0] DMA_WORD,
  input wire logic [15:0] DMA_ADDR,
  input wire logic [15:0] REMOTE_START,
  input wire logic [4:0] FIFO_LEVEL,
  input wire logic SEND_CMD,
  output logic [15:0] BUS_DATA,
  output logic [15:0] BUS_ADDR,
  output logic [15:0] BUS_ADDR_HIGH,
  output logic WORD_MODE,
  output logic LONG_ADDR,
  output logic [1:0] LOOP_MODE,
  output logic SEND_EXEC,
  output logic BUS_REQ,
  output logic [4:0] RX_THRESH,
  output logic [4:0] TX_THRESH,
  output logic [3:0] BURST_LEN
);
  import dcfg_pkg::*;

  logic [6:0] cfg_q;
  logic [1:0] loop_code_q;
  logic [1:0] ft_code;
  logic word_sel;
  logic order_sel;
  logic long_sel;
  logic loop_sel;
  logic auto_init;
  logic swap_lanes;
  wire logic [15:0] lane_d;
  logic [4:0] rx_bytes;
  logic [4:0] tx_bytes;
  logic [3:0] burst_units;
  loop_mode_t loop_d;

  assign word_sel = cfg_q[WORD_SEL_BIT];
  assign order_sel = cfg_q[ORDER_SEL_BIT];
  assign long_sel = cfg_q[LONG_SEL_BIT];
  assign loop_sel = cfg_q[LSEL_BIT];
  assign auto_init = cfg_q[ARM_BIT];
  assign ft_code = cfg_q[FT_LSB+1:FT_LSB];
  // Order bit only steers word transfers
  assign swap_lanes = word_sel && order_sel;

  // Only seven bits are held, so a write to bit seven changes nothing
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cfg_q <= DATA_CONFIG_RST[6:0];
    end else if (WR && ADDR == DATA_CONFIG_OFS) begin
      cfg_q <= WDATA[6:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      loop_code_q <= LOOP_CODE_RST;
    end else if (WR && ADDR == TX_CONFIG_OFS) begin
      loop_code_q <= WDATA[LBC_LSB+1:LBC_LSB];
    end
  end

  // Both registers are write-only; a read returns zero at any address
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RDATA <= UNMAPPED_READ;
    end else begin
      RDATA <= UNMAPPED_READ;
    end
  end

  // Loopback needs both the select bit low and a nonzero code from software
  always_comb begin
    if (loop_sel) begin
      loop_d = LB_NORMAL;
    end else begin
      case (loop_code_q)
        2'b01: loop_d = LB_CONTROLLER;
        2'b10: loop_d = LB_ENCODER;
        2'b11: loop_d = LB_EXTERNAL;
        default: loop_d = LB_NORMAL;
      endcase
    end
  end

  // One byte lane per pass; when swapped a lane takes its partner's byte
  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign lane_d[8*g +: 8] = swap_lanes ? DMA_WORD[8*(1-g) +: 8] : DMA_WORD[8*g +: 8];
  end

  dcfg_thresh u_thresh (
    .clk(REF_CLK),
    .rst(RST),
    .code(ft_code),
    .word_mode(word_sel),
    .rx_bytes_q(rx_bytes),
    .tx_bytes_q(tx_bytes),
    .burst_units_q(burst_units)
  );

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      WORD_MODE <= DATA_CONFIG_RST[WORD_SEL_BIT];
    end else begin
      WORD_MODE <= word_sel;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      LONG_ADDR <= DATA_CONFIG_RST[LONG_SEL_BIT];
    end else begin
      LONG_ADDR <= long_sel;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      LOOP_MODE <= LB_NORMAL;
    end else begin
      LOOP_MODE <= loop_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      BUS_DATA <= 16'h0000;
    end else begin
      BUS_DATA <= lane_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      BUS_ADDR <= 16'h0000;
    end else begin
      BUS_ADDR <= word_sel ? {DMA_ADDR[15:1], 1'b0} : DMA_ADDR;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      BUS_ADDR_HIGH <= 16'h0000;
    end else begin
      BUS_ADDR_HIGH <= long_sel ? REMOTE_START : 16'h0000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      SEND_EXEC <= 1'b0;
    end else begin
      SEND_EXEC <= SEND_CMD && auto_init;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      BUS_REQ <= 1'b0;
    end else begin
      BUS_REQ <= FIFO_LEVEL >= rx_bytes;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RX_THRESH <= RX_THRESH_RST;
      TX_THRESH <= TX_THRESH_RST;
      BURST_LEN <= BURST_LEN_RST;
    end else begin
      RX_THRESH <= rx_bytes;
      TX_THRESH <= tx_bytes;
      BURST_LEN <= burst_units;
    end
  end

  word_out_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST)
    |-> WORD_MODE == $past(word_sel))
    else $error("Word mode output wrong");
  lsb_low_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(word_sel)
    |-> !BUS_ADDR[0])
    else $error("Address bit zero high in word mode");
  byte_addr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && !$past(word_sel)
    |-> BUS_ADDR == $past(DMA_ADDR))
    else $error("Byte mode address altered");
  word_addr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(word_sel)
    |-> BUS_ADDR[15:1] == $past(DMA_ADDR[15:1]))
    else $error("Word mode upper address altered");
  lane_swap_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(word_sel && order_sel)
    |-> BUS_DATA == {$past(DMA_WORD[7:0]), $past(DMA_WORD[15:8])})
    else $error("Byte lanes not swapped");
  lane_keep_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(word_sel && !order_sel)
    |-> BUS_DATA == $past(DMA_WORD))
    else $error("Byte lanes swapped with order bit low");
  byte_order_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(!word_sel)
    |-> BUS_DATA == $past(DMA_WORD))
    else $error("Order applied in byte mode");
  high_addr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(long_sel)
    |-> BUS_ADDR_HIGH == $past(REMOTE_START))
    else $error("High address wrong");
  dual_addr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(!long_sel)
    |-> BUS_ADDR_HIGH == 16'h0000)
    else $error("High address driven in dual mode");
  long_out_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST)
    |-> LONG_ADDR == $past(long_sel))
    else $error("Long address output wrong");
  reset_las_a: assert property (@(posedge REF_CLK)
    $past(RST)
    |-> LONG_ADDR && cfg_q[LONG_SEL_BIT])
    else $error("Long address not set at reset");
  reset_cfg_a: assert property (@(posedge REF_CLK)
    $past(RST)
    |-> cfg_q == DATA_CONFIG_RST[6:0] && loop_code_q == LOOP_CODE_RST)
    else $error("Configuration not at reset value");
  normal_loop_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(loop_sel)
    |-> LOOP_MODE == LB_NORMAL)
    else $error("Loopback while select high");
  loop_pick_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && !$past(loop_sel)
    |-> LOOP_MODE == $past(loop_code_q))
    else $error("Loopback mode does not follow code");
  loop_load_a: assert property (@(posedge REF_CLK) disable iff (RST)
    WR && ADDR == TX_CONFIG_OFS
    |=> loop_code_q == $past(WDATA[LBC_LSB+1:LBC_LSB]))
    else $error("Loopback code write mishandled");
  send_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
    SEND_EXEC
    |-> $past(auto_init && SEND_CMD))
    else $error("Send executed without auto-init");
  send_fire_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(auto_init && SEND_CMD)
    |-> SEND_EXEC)
    else $error("Send not executed with auto-init");
  rx_two_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(ft_code, 2) == 2'b00
    |-> RX_THRESH == {THRESH_UNITS_0, 1'b0})
    else $error("Receive threshold wrong for code 0");
  rx_four_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(ft_code, 2) == 2'b01
    |-> RX_THRESH == {THRESH_UNITS_1, 1'b0})
    else $error("Receive threshold wrong for code 1");
  rx_eight_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(ft_code, 2) == 2'b10
    |-> RX_THRESH == {THRESH_UNITS_2, 1'b0})
    else $error("Receive threshold wrong for code 2");
  rx_thresh_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(ft_code, 2) == 2'b11
    |-> RX_THRESH == {THRESH_UNITS_3, 1'b0})
    else $error("Receive threshold wrong for code 3");
  bus_req_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST)
    |-> BUS_REQ == ($past(FIFO_LEVEL) >= RX_THRESH))
    else $error("Bus request does not follow threshold");
  burst_word_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && $past(word_sel, 2)
    |-> {BURST_LEN, 1'b0} == RX_THRESH)
    else $error("Word burst length wrong");
  burst_byte_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST) && !$past(word_sel, 2)
    |-> {1'b0, BURST_LEN} == RX_THRESH)
    else $error("Byte burst length wrong");
  tx_sum_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !$past(RST)
    |-> RX_THRESH + TX_THRESH == FIFO_BYTES)
    else $error("Transmit threshold wrong");
  unused_bit_a: assert property (@(posedge REF_CLK) disable iff (RST)
    WR && ADDR == DATA_CONFIG_OFS
    |=> cfg_q == $past(WDATA[6:0]))
    else $error("Config write mishandled");
  other_addr_a: assert property (@(posedge REF_CLK) disable iff (RST)
    WR && ADDR != DATA_CONFIG_OFS
    |=> $stable(cfg_q))
    else $error("Config changed by another address");
  read_zero_a: assert property (@(posedge REF_CLK) disable iff (RST)
    RD
    |=> RDATA == UNMAPPED_READ)
    else $error("Read data not zero");
endmodule : dcfg_top
`default_nettype wire

// >>> verification/host_bus.sv
// Host model: issues one-cycle register strobes on the configuration port
`timescale 1ns/100ps
`default_nettype none
module host_bus (
  input wire logic clk,
  output logic [dcfg_pkg::ADDR_W-1:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  import dcfg_pkg::*;
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Software loads the config before any byte count
  task automatic put(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    // Released data never keeps its last value
    wdata <= ~d;
  endtask : put
endmodule : host_bus
`default_nettype wire

// >>> verification/dma_data_config_reg_test.sv
// Testbench: random configurations compared against a behavioural model
`timescale 1ns/100ps
`default_nettype none
module dma_data_config_reg_test;
  import dcfg_pkg::*;
  logic clk, rst, wr, rd, snd, BUS_REQ, WORD_MODE, LONG_ADDR, SEND_EXEC;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, RDATA, c;
  logic [15:0] dw, da, rs, BUS_DATA, BUS_ADDR, BUS_ADDR_HIGH;
  logic [4:0] lvl, RX_THRESH, TX_THRESH;
  logic [3:0] BURST_LEN;
  logic [1:0] lbc, LOOP_MODE;
  int seed, n_errors, comparisons, rx;
  logic [31:0] r;
  host_bus i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  dcfg_top i_dut (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(RDATA), .DMA_WORD(dw), .DMA_ADDR(da), .REMOTE_START(rs), .FIFO_LEVEL(lvl),
    .SEND_CMD(snd), .BUS_DATA(BUS_DATA), .BUS_ADDR(BUS_ADDR), .BUS_ADDR_HIGH(BUS_ADDR_HIGH),
    .WORD_MODE(WORD_MODE), .LONG_ADDR(LONG_ADDR), .LOOP_MODE(LOOP_MODE), .SEND_EXEC(SEND_EXEC),
    .BUS_REQ(BUS_REQ), .RX_THRESH(RX_THRESH), .TX_THRESH(TX_THRESH), .BURST_LEN(BURST_LEN));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h2E112996;
    {rst, snd, dw, da, rs, lvl, c, lbc} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("long_addr", 16'h1, 16'(LONG_ADDR));
    chk("tx_thresh", 16'hE, 16'(TX_THRESH));
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      r = $random(seed);
      {dw, da} <= r;
      r = $random(seed);
      {rs, lvl} <= r[31:11];
      snd <= 1'b0;
      // The written byte must be settled before the host task takes it
      {lbc, c} = r[9:0];
      // Bit 7 stays random to show it is ignored
      i_host.put(DATA_CONFIG_OFS, c, 1'b1);
      i_host.put(TX_CONFIG_OFS, {5'h0, lbc, 1'b0}, 1'b1);
      i_host.put(4'h3, ~c, 1'b1);
      i_host.put(DATA_CONFIG_OFS, 8'h0, 1'b0);
      #1;
      chk("rdata", 16'h0, 16'(RDATA));
      @(posedge clk);
      snd <= r[10] & ~(c[0] & c[1]);
      repeat (4) @(posedge clk);
      #1;
      rx = (c[6:5] == 2'h3) ? 12 : 2 << c[6:5];
      chk("bus_data", (c[0] & c[1]) ? {dw[7:0], dw[15:8]} : dw, BUS_DATA);
      chk("bus_addr", c[0] ? {da[15:1], 1'b0} : da, BUS_ADDR);
      chk("addr_high", c[2] ? rs : 16'h0, BUS_ADDR_HIGH);
      chk("long_addr", 16'(c[2]), 16'(LONG_ADDR));
      chk("word_mode", 16'(c[0]), 16'(WORD_MODE));
      chk("loop_mode", c[3] ? 16'h0 : 16'(lbc), 16'(LOOP_MODE));
      chk("send_exec", 16'(snd & c[4]), 16'(SEND_EXEC));
      chk("rx_thresh", 16'(rx), 16'(RX_THRESH));
      chk("tx_thresh", 16'(16 - rx), 16'(TX_THRESH));
      chk("burst_len", 16'(c[0] ? rx / 2 : rx), 16'(BURST_LEN));
      chk("bus_req", 16'(int'(lvl) >= rx), 16'(BUS_REQ));
      $display("test %0d done", i);
    end
    tally_and_finish();
  end
endmodule : dma_data_config_reg_test
`default_nettype wire
